// *** src/tie_pkg.sv ***
package tie_pkg;
   localparam int ADDR_W = 4;
   localparam int BANK_W = 8;
   localparam logic [ADDR_W-1:0] OFS_ENABLE = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_MASK = 4'h8;
   localparam logic [ADDR_W-1:0] OFS_GATED = 4'hc;
   localparam logic [BANK_W-1:0] ENABLE_RST = 8'h00;
   localparam logic [BANK_W-1:0] ENABLE_IMPL = 8'h7f;
   localparam logic [BANK_W-1:0] STATUS_RST = 8'h00;
   localparam logic [BANK_W-1:0] MASK_RST = 8'h00;
   localparam int POS_T8_MATCH = 6;
   localparam int POS_T5_GATE = 5;
   localparam int POS_T5_MATCH = 4;
   localparam int POS_T3_GATE = 3;
   localparam int POS_T3_MATCH = 2;
   localparam int POS_T6_MATCH = 1;
   localparam int POS_T4_MATCH = 0;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// *** src/tie_gate_if.sv ***
interface tie_gate_if;
   import tie_pkg::*;
   logic [BANK_W-1:0] flags;
   logic [BANK_W-1:0] enables;
   logic [BANK_W-1:0] gated;
   logic anyReq;
   modport gate (input flags, input enables, output gated, output anyReq);
   modport user (output flags, output enables, input gated, input anyReq);
endinterface

// *** src/tie_gate.sv ***
module tie_gate (
   tie_gate_if.gate g
);
   import tie_pkg::*;
   assign g.gated[POS_T8_MATCH] = g.flags[POS_T8_MATCH] & g.enables[POS_T8_MATCH];
   assign g.gated[POS_T5_GATE] = g.flags[POS_T5_GATE] & g.enables[POS_T5_GATE];
   assign g.gated[POS_T5_MATCH] = g.flags[POS_T5_MATCH] & g.enables[POS_T5_MATCH];
   assign g.gated[POS_T3_GATE] = g.flags[POS_T3_GATE] & g.enables[POS_T3_GATE];
   assign g.gated[POS_T3_MATCH] = g.flags[POS_T3_MATCH] & g.enables[POS_T3_MATCH];
   assign g.gated[POS_T6_MATCH] = g.flags[POS_T6_MATCH] & g.enables[POS_T6_MATCH];
   assign g.gated[POS_T4_MATCH] = g.flags[POS_T4_MATCH] & g.enables[POS_T4_MATCH];
   // Bit 7 unimplemented, never requests
   assign g.gated[7] = 1'b0;
   assign g.anyReq = |g.gated;
endmodule

// *** src/tie_bank.sv ***
// The register offsets and the AXI4-Lite register port were chosen for this implementation.
module tie_bank (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic [tie_pkg::BANK_W-1:0] timerFlags,
   output logic periphIrq,
   output logic irq,
   input wire logic [tie_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [tie_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   import tie_pkg::*;

   logic [BANK_W-1:0] enable_reg, enable_next;
   logic [BANK_W-1:0] status_reg, status_next;
   logic [BANK_W-1:0] mask_reg, mask_next;
   logic [BANK_W-1:0] flagsPrev_reg;
   logic periphIrq_reg, irq_reg;
   logic awHeld_reg, wHeld_reg;
   logic [ADDR_W-1:0] awAddr_reg;
   logic [31:0] wData_reg;
   logic [3:0] wStrb_reg;
   logic bValid_reg, rValid_reg;
   logic [1:0] bResp_reg, rResp_reg;
   logic [31:0] rData_reg;
   logic awReady_reg, wReady_reg, arReady_reg;

   tie_gate_if gi ();
   tie_gate u_gate (.g(gi));

   assign gi.flags = timerFlags;
   assign gi.enables = enable_reg;

   function automatic logic known(input logic [ADDR_W-1:0] a);
      known = (a == OFS_ENABLE) || (a == OFS_STATUS) || (a == OFS_MASK) || (a == OFS_GATED);
   endfunction

   // Write path: address and data latched independently
   wire awTake = s_axi_awvalid & ~awHeld_reg & ~bValid_reg;
   wire wTake = s_axi_wvalid & ~wHeld_reg & ~bValid_reg;
   wire doWrite = awHeld_reg & wHeld_reg & ~bValid_reg;
   wire wrLane0 = doWrite & wStrb_reg[0];
   wire wrEnable = wrLane0 & (awAddr_reg == OFS_ENABLE);
   wire wrStatus = wrLane0 & (awAddr_reg == OFS_STATUS);
   wire wrMask = wrLane0 & (awAddr_reg == OFS_MASK);
   wire awHeld_next = ~doWrite & (awTake | awHeld_reg);
   wire wHeld_next = ~doWrite & (wTake | wHeld_reg);
   wire bValid_next = doWrite | (bValid_reg & ~s_axi_bready);

   // Events are rising edges of gated requests; set beats write-one-to-clear
   wire [BANK_W-1:0] events = gi.gated & ~flagsPrev_reg;
   wire [BANK_W-1:0] clrBits = wrStatus ? wData_reg[BANK_W-1:0] : '0;

   assign enable_next = wrEnable ? (wData_reg[BANK_W-1:0] & ENABLE_IMPL) : enable_reg;
   assign status_next = (status_reg & ~clrBits) | events;
   assign mask_next = wrMask ? (wData_reg[BANK_W-1:0] & ENABLE_IMPL) : mask_reg;

   wire arTake = s_axi_arvalid & ~rValid_reg;
   wire rValid_next = arTake | (rValid_reg & ~s_axi_rready);
   wire [BANK_W-1:0] rdSel = (s_axi_araddr == OFS_ENABLE) ? enable_reg :
                             (s_axi_araddr == OFS_STATUS) ? status_reg :
                             (s_axi_araddr == OFS_MASK) ? mask_reg :
                             (s_axi_araddr == OFS_GATED) ? gi.gated : '0;

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         enable_reg <= ENABLE_RST;
         status_reg <= STATUS_RST;
         mask_reg <= MASK_RST;
         flagsPrev_reg <= '0;
         periphIrq_reg <= 1'b0;
         irq_reg <= 1'b0;
      end else begin
         enable_reg <= enable_next;
         status_reg <= status_next;
         mask_reg <= mask_next;
         flagsPrev_reg <= gi.gated;
         periphIrq_reg <= gi.anyReq;
         irq_reg <= |(status_next & mask_next);
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         awHeld_reg <= 1'b0;
         wHeld_reg <= 1'b0;
         awAddr_reg <= '0;
         wData_reg <= '0;
         wStrb_reg <= '0;
         bValid_reg <= 1'b0;
         bResp_reg <= RESP_OKAY;
         awReady_reg <= 1'b1;
         wReady_reg <= 1'b1;
      end else begin
         awReady_reg <= ~awHeld_next & ~bValid_next;
         wReady_reg <= ~wHeld_next & ~bValid_next;
         if (awTake) begin
            awHeld_reg <= 1'b1;
            awAddr_reg <= s_axi_awaddr;
         end
         if (wTake) begin
            wHeld_reg <= 1'b1;
            wData_reg <= s_axi_wdata;
            wStrb_reg <= s_axi_wstrb;
         end
         if (doWrite) begin
            awHeld_reg <= 1'b0;
            wHeld_reg <= 1'b0;
            bValid_reg <= 1'b1;
            bResp_reg <= known(awAddr_reg) ? RESP_OKAY : RESP_SLVERR;
         end else if (bValid_reg && s_axi_bready) begin
            bValid_reg <= 1'b0;
         end
      end
   end

   // Ready flops carry the value the held state will have, so timing matches a decode of it
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         arReady_reg <= 1'b1;
      end else begin
         arReady_reg <= ~rValid_next;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         rValid_reg <= 1'b0;
         rData_reg <= '0;
         rResp_reg <= RESP_OKAY;
      end else if (arTake) begin
         rValid_reg <= 1'b1;
         rData_reg <= {24'h000000, rdSel};
         rResp_reg <= known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (rValid_reg && s_axi_rready) begin
         rValid_reg <= 1'b0;
      end
   end

   assign s_axi_awready = awReady_reg;
   assign s_axi_wready = wReady_reg;
   assign s_axi_bvalid = bValid_reg;
   assign s_axi_bresp = bResp_reg;
   assign s_axi_arready = arReady_reg;
   assign s_axi_rvalid = rValid_reg;
   assign s_axi_rdata = rData_reg;
   assign s_axi_rresp = rResp_reg;
   assign periphIrq = periphIrq_reg;
   assign irq = irq_reg;
endmodule

// *** verif/tie_bank_checker.sv ***
module tie_bank_checker (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic [tie_pkg::BANK_W-1:0] timerFlags,
   input wire logic periphIrq,
   input wire logic irq,
   input wire logic [tie_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid
);
   timeunit 1ns/1ps;
   import tie_pkg::*;
   logic [6:0] enShadow_reg;
   logic [6:0] enData_reg;
   logic enPend_reg;
   wire taken = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready;
   wire enWrite = taken & (s_axi_awaddr == OFS_ENABLE) & s_axi_wstrb[0];
   wire [7:0] gatedNow = timerFlags & {1'h0, enShadow_reg};
   // Bank commits one edge after both halves are taken
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         enShadow_reg <= 7'h00;
         enData_reg <= 7'h00;
         enPend_reg <= 1'b0;
      end else begin
         enPend_reg <= enWrite;
         enData_reg <= s_axi_wdata[6:0];
         if (enPend_reg) enShadow_reg <= enData_reg;
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   property gatePass(int k);
      timerFlags[6:0] == (7'h01 << k) |=> periphIrq == $past(enShadow_reg[k]);
   endproperty
   t8_match_a: assert property (gatePass(6)) else $error("t8 match");
   t5_gate_a: assert property (gatePass(5)) else $error("t5 gate");
   t5_match_a: assert property (gatePass(4)) else $error("t5 match");
   t3_gate_a: assert property (gatePass(3)) else $error("t3 gate");
   t3_match_a: assert property (gatePass(2)) else $error("t3 match");
   t6_match_a: assert property (gatePass(1)) else $error("t6 match");
   t4_match_a: assert property (gatePass(0)) else $error("t4 match");
   any_req_a: assert property (periphIrq == |$past(gatedNow)) else $error("any req");
   write_resp_a: assert property (taken |-> ##2 s_axi_bvalid) else $error("write resp");
   cover property (enWrite);
   cover property ($rose(periphIrq));
   cover property ($rose(irq));
endmodule

bind tie_bank tie_bank_checker i_tie_bank_checker (.*);

// *** verif/tie_timer_model.sv ***
module tie_timer_model (
   input wire logic clk_sys,
   input wire logic [7:0] want,
   output logic [7:0] timerFlags = 8'h00
);
   timeunit 1ns/1ps;
   // Flags move just after the edge, as a timer flop would
   always @(posedge clk_sys) timerFlags <= want;
endmodule

// *** verif/tie_bank_bench.sv ***
module tie_bank_bench;
   timeunit 1ns/1ps;
   import tie_pkg::*;
   logic clk_sys = 1'h0, rstn = 1'h0, periphIrq, irq, s_axi_bvalid, s_axi_rvalid;
   logic s_axi_awvalid = 1'h0, s_axi_awready, s_axi_wvalid = 1'h0, s_axi_wready, s_axi_bready = 1'h1;
   logic s_axi_arvalid = 1'h0, s_axi_arready, s_axi_rready = 1'h1;
   logic [7:0] timerFlags, want = 8'h00;
   logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h1;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   // Enable, flags, expected request
   logic [16:0] rows [8] = '{{8'h40, 8'h40, 1'h1}, {8'h5f, 8'h20, 1'h0}, {8'h10, 8'hff, 1'h1},
      {8'h77, 8'h08, 1'h0}, {8'h04, 8'h04, 1'h1}, {8'h7d, 8'h02, 1'h0}, {8'h01, 8'h81, 1'h1},
      {8'hff, 8'h80, 1'h0}};
   int failures = 0, cmp_count = 0, cycles = 0;
   always #4 clk_sys = ~clk_sys;
   tie_timer_model i_tie_timer_model (.clk_sys, .want, .timerFlags);
   tie_bank i_tie_bank (.*);
   task report_and_stop;
      if (failures == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task chk(string n, logic [31:0] e, logic [31:0] s);
      cmp_count++;
      if (s !== e) begin
         failures++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask
   task wr(logic [3:0] a, logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      do @(posedge clk_sys); while (!(s_axi_awready && s_axi_wready));
      s_axi_awvalid <= 1'h0;
      s_axi_wvalid <= 1'h0;
      do @(posedge clk_sys); while (!s_axi_bvalid);
      chk("bresp", 32'(RESP_OKAY), 32'(s_axi_bresp));
   endtask
   task rd(logic [3:0] a, logic [31:0] e, logic [1:0] r);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      do @(posedge clk_sys); while (!s_axi_arready);
      s_axi_arvalid <= 1'h0;
      do @(posedge clk_sys); while (!s_axi_rvalid);
      chk("rdata", e, s_axi_rdata);
      chk("rresp", 32'(r), 32'(s_axi_rresp));
   endtask
   task irqStep(logic [3:0] a, logic [31:0] d, logic e);
      wr(a, d);
      repeat (2) @(posedge clk_sys);
      chk("irq", 32'(e), 32'(irq));
   endtask
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles > 3000) begin
         failures++;
         report_and_stop;
      end
   end
   initial begin
      repeat (12) @(posedge clk_sys);
      rstn <= 1'h1;
      @(posedge clk_sys);
      rd(OFS_ENABLE, 32'h0, RESP_OKAY);
      rd(4'h2, 32'h0, RESP_SLVERR);
      foreach (rows[i]) begin
         wr(OFS_ENABLE, 32'(rows[i][16:9]));
         rd(OFS_ENABLE, 32'(rows[i][16:9] & ENABLE_IMPL), RESP_OKAY);
         want <= rows[i][8:1];
         repeat (3) @(posedge clk_sys);
         chk("periphIrq", 32'(rows[i][0]), 32'(periphIrq));
      end
      s_axi_wstrb <= 4'h0;
      wr(OFS_ENABLE, 32'h01);
      s_axi_wstrb <= 4'h1;
      rd(OFS_ENABLE, 32'h7f, RESP_OKAY);
      want <= 8'h00;
      wr(OFS_STATUS, 32'hff);
      wr(OFS_MASK, 32'h01);
      wr(OFS_ENABLE, 32'h01);
      want <= 8'h01;
      repeat (4) @(posedge clk_sys);
      chk("irq", 32'h1, 32'(irq));
      irqStep(OFS_MASK, 32'h0, 1'h0);
      irqStep(OFS_MASK, 32'h01, 1'h1);
      irqStep(OFS_STATUS, 32'h01, 1'h0);
      rstn <= 1'h0;
      repeat (2) @(posedge clk_sys);
      rstn <= 1'h1;
      @(posedge clk_sys);
      rd(OFS_ENABLE, 32'h0, RESP_OKAY);
      report_and_stop;
   end
endmodule
